// >>> design/ocs_status_bank.v
// Overcurrent (ten half-bridges) and open-load (bridges 1-4 only) read-and-clear status bank
// Functional notes
// [RULE1] High-side overcurrent sets a latched flag and switches that high side off.
// [RULE2] Low-side overcurrent sets a latched flag and switches that low side off.
// [RULE3] Byte one: bridges 1-4, low side even bit, high side odd bit.
// [RULE4] Byte two at address code 011 10: bridges 5-8, same pairing.
// [RULE5] Byte three at address code 111 10 reports bridges 9 and 10.
// [RULE6] Byte three: bridge 9 at bits 0-1, bridge 10 at bits 2-3.
// [RULE7] Byte three bits 4 to 7 always read zero.
// [RULE8] Status bits of absent or unconnected outputs read as zero.
// [RULE9] Open-load byte one at address code 000 01: bridges 1-4 paired.
// [RULE10] Overcurrent flags reset to zero and rise only on a detected fault.
// [RULE11] Master reads with address bit 7 low, clears with bit 7 high.
// [RULE12] Device never clears a flag itself; only a clear command does.
// [RULE13] Global load error is the OR of all overcurrent and open-load flags.
// [RULE14] A tripped switch stays off until its overcurrent flag is cleared.
`timescale 1ns/1ns
`include "ocs_consts.vh"
module ocs_status_bank #(
  parameter NUM_BRIDGES = `OCS_NUM_BRIDGES,
  parameter [`OCS_NUM_BRIDGES-1:0] BRIDGE_PRESENT = 10'h3ff
) (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire cmd_valid,
  input wire [7:0] cmd_addr,
  input wire [`OCS_NUM_BRIDGES-1:0] high_side_overcurrent_event,
  input wire [`OCS_NUM_BRIDGES-1:0] low_side_overcurrent_event,
  input wire [`OCS_OL_BRIDGES-1:0] high_side_open_load_event,
  input wire [`OCS_OL_BRIDGES-1:0] low_side_open_load_event,
  input wire [`OCS_NUM_BRIDGES-1:0] high_side_switch_request,
  input wire [`OCS_NUM_BRIDGES-1:0] low_side_switch_request,
  output reg [7:0] rsp_data,
  output reg rsp_valid,
  output reg [`OCS_NUM_BRIDGES-1:0] high_side_switch,
  output reg [`OCS_NUM_BRIDGES-1:0] low_side_switch,
  output reg global_load_error
);

  // ****************************************
  // Flag storage
  // ****************************************
  reg [`OCS_NUM_BRIDGES-1:0] high_side_overcurrent_flag;
  reg [`OCS_NUM_BRIDGES-1:0] low_side_overcurrent_flag;
  reg [`OCS_OL_BRIDGES-1:0] high_side_open_load_flag;
  reg [`OCS_OL_BRIDGES-1:0] low_side_open_load_flag;

  // ****************************************
  // Present-output mask
  // ****************************************
  // Smaller variants leave outputs unbonded; their flags never latch, so they read zero
  wire [`OCS_NUM_BRIDGES-1:0] present_mask;
  genvar p;
  generate
    for (p = 0; p < `OCS_NUM_BRIDGES; p = p + 1) begin : g_present
      assign present_mask[p] = BRIDGE_PRESENT[p] && (p < NUM_BRIDGES); // [RULE8]
    end
  endgenerate

  // ****************************************
  // Command decode
  // ****************************************
  // Bit 0 of the address byte is not decoded; the frame engine checks it
  wire [`OCS_SEL_W-1:0] sel;
  wire clear_cmd;
  wire oc1_hit;
  wire oc2_hit;
  wire oc3_hit;
  wire ol1_hit;
  wire glb_hit;
  assign sel = cmd_addr[`OCS_SEL_HI:`OCS_SEL_LO];
  assign clear_cmd = cmd_valid & cmd_addr[`OCS_OP_BIT]; // [RULE11]
  assign oc1_hit = (sel == `OCS_SEL_OC1); // [RULE3]
  assign oc2_hit = (sel == `OCS_SEL_OC2); // [RULE4]
  assign oc3_hit = (sel == `OCS_SEL_OC3); // [RULE5]
  assign ol1_hit = (sel == `OCS_SEL_OL1); // [RULE9]
  assign glb_hit = (sel == `OCS_SEL_GLB); // [RULE13]

  // Bridge index range a register clear touches
  function [`OCS_NUM_BRIDGES-1:0] oc_clear_mask;
    input [`OCS_SEL_W-1:0] s;
    begin
      if (s == `OCS_SEL_OC1) begin
        oc_clear_mask = `OCS_MASK_OC1;
      end else if (s == `OCS_SEL_OC2) begin
        oc_clear_mask = `OCS_MASK_OC2;
      end else if (s == `OCS_SEL_OC3) begin
        oc_clear_mask = `OCS_MASK_OC3;
      end else begin
        oc_clear_mask = `OCS_MASK_NONE;
      end
    end
  endfunction

  // Interleave low and high flags of four bridges into one byte
  function [7:0] pack_pairs;
    input [3:0] ls;
    input [3:0] hs;
    integer k;
    begin
      pack_pairs = 8'h00;
      for (k = 0; k < 4; k = k + 1) begin
        pack_pairs[2*k] = ls[k];
        pack_pairs[2*k+1] = hs[k];
      end
    end
  endfunction

  wire [`OCS_NUM_BRIDGES-1:0] oc_clr = clear_cmd ? oc_clear_mask(sel) : `OCS_MASK_NONE;
  wire ol_clr = clear_cmd & ol1_hit;

  // ****************************************
  // Per-switch latches
  // ****************************************
  genvar b;
  generate
    for (b = 0; b < `OCS_NUM_BRIDGES; b = b + 1) begin : g_bridge
      wire next_high_side_switch;
      wire next_low_side_switch;
      // Cut in the same cycle as the fault, and held off while latched
      assign next_high_side_switch = high_side_switch_request[b] & ~high_side_overcurrent_event[b] &
        ~high_side_overcurrent_flag[b] & present_mask[b]; // [RULE1] [RULE14]
      assign next_low_side_switch = low_side_switch_request[b] & ~low_side_overcurrent_event[b] &
        ~low_side_overcurrent_flag[b] & present_mask[b]; // [RULE2] [RULE14]
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          high_side_overcurrent_flag[b] <= 1'b0; // [RULE10]
          low_side_overcurrent_flag[b] <= 1'b0;
          high_side_switch[b] <= 1'b0;
          low_side_switch[b] <= 1'b0;
        end else if (clk_en) begin
          // Set wins over a clear in the same cycle; absent outputs never latch
          if (present_mask[b] && high_side_overcurrent_event[b]) begin
            high_side_overcurrent_flag[b] <= 1'b1; // [RULE1] [RULE8]
          end else if (oc_clr[b]) begin
            high_side_overcurrent_flag[b] <= 1'b0; // [RULE12]
          end
          if (present_mask[b] && low_side_overcurrent_event[b]) begin
            low_side_overcurrent_flag[b] <= 1'b1; // [RULE2] [RULE8]
          end else if (oc_clr[b]) begin
            low_side_overcurrent_flag[b] <= 1'b0; // [RULE12]
          end
          high_side_switch[b] <= next_high_side_switch; // [RULE1]
          low_side_switch[b] <= next_low_side_switch; // [RULE2]
        end
      end
    end
    for (b = 0; b < `OCS_OL_BRIDGES; b = b + 1) begin : g_ol
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          high_side_open_load_flag[b] <= 1'b0;
          low_side_open_load_flag[b] <= 1'b0;
        end else if (clk_en) begin
          if (present_mask[b] && high_side_open_load_event[b]) begin
            high_side_open_load_flag[b] <= 1'b1; // [RULE9]
          end else if (ol_clr) begin
            high_side_open_load_flag[b] <= 1'b0; // [RULE12]
          end
          if (present_mask[b] && low_side_open_load_event[b]) begin
            low_side_open_load_flag[b] <= 1'b1; // [RULE9]
          end else if (ol_clr) begin
            low_side_open_load_flag[b] <= 1'b0; // [RULE12]
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  // Packed views, so the read mux only selects
  wire [7:0] oc1_byte;
  wire [7:0] oc2_byte;
  wire [7:0] oc3_byte;
  wire [7:0] ol1_byte;
  assign oc1_byte = pack_pairs(low_side_overcurrent_flag[3:0], high_side_overcurrent_flag[3:0]); // [RULE3]
  assign oc2_byte = pack_pairs(low_side_overcurrent_flag[7:4], high_side_overcurrent_flag[7:4]); // [RULE4]
  assign oc3_byte = pack_pairs({2'b00, low_side_overcurrent_flag[9:8]},
    {2'b00, high_side_overcurrent_flag[9:8]}); // [RULE6] [RULE7]
  assign ol1_byte = pack_pairs(low_side_open_load_flag, high_side_open_load_flag); // [RULE9]

  reg [7:0] next_rsp_data;
  always @* begin
    // Read returns content before any clear in the same frame
    next_rsp_data = `OCS_STAT_RESET;
    if (oc1_hit) begin
      next_rsp_data = oc1_byte; // [RULE3]
    end else if (oc2_hit) begin
      next_rsp_data = oc2_byte; // [RULE4]
    end else if (oc3_hit) begin
      next_rsp_data = oc3_byte; // [RULE5] [RULE7]
    end else if (ol1_hit) begin
      next_rsp_data = ol1_byte; // [RULE9]
    end else if (glb_hit) begin
      next_rsp_data[`OCS_GLB_LE_BIT] = global_load_error; // [RULE13]
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_data <= `OCS_STAT_RESET;
      rsp_valid <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        rsp_data <= next_rsp_data;
      end
    end
  end

  // ****************************************
  // Global load error
  // ****************************************
  // Registered, so it trails the flags by one cycle; keeps the wide OR off the output
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      global_load_error <= 1'b0;
    end else if (clk_en) begin
      global_load_error <= |{high_side_overcurrent_flag, low_side_overcurrent_flag,
        high_side_open_load_flag, low_side_open_load_flag}; // [RULE13]
    end
  end

endmodule

// >>> inc/ocs_consts.vh
// Address codes, field positions and reset values of the overcurrent status bank
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH
// Address byte: bit 7 selects operation, bits 6..1 select the register, bit 0 is always 1
`define OCS_OP_BIT 7
`define OCS_SEL_HI 6
`define OCS_SEL_LO 1
`define OCS_SEL_W 6
`define OCS_SEL_OC1 6'h2d
`define OCS_SEL_OC2 6'h1d
`define OCS_SEL_OC3 6'h3d
`define OCS_SEL_OL1 6'h03
`define OCS_SEL_GLB 6'h0d
`define OCS_STAT_RESET 8'h00
`define OCS_MASK_OC1 10'h00f
`define OCS_MASK_OC2 10'h0f0
`define OCS_MASK_OC3 10'h300
`define OCS_MASK_NONE 10'h000
`define OCS_GLB_LE_BIT 6
`define OCS_NUM_BRIDGES 10
`define OCS_BRIDGES_PER_BYTE 4
`define OCS_OL_BRIDGES 4
`endif

// >>> testbench/ocs_status_bank_sva.sv
// Assertions on the ports of the status bank
`timescale 1ns/1ns
module ocs_status_bank_sva (
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire cmd_valid,
  input wire [7:0] cmd_addr,
  input wire [9:0] high_side_overcurrent_event,
  input wire [9:0] low_side_overcurrent_event,
  input wire [7:0] rsp_data,
  input wire rsp_valid,
  input wire [9:0] high_side_switch,
  input wire [9:0] low_side_switch,
  input wire global_load_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence oc_hit; clk_en && |{high_side_overcurrent_event, low_side_overcurrent_event}; endsequence
  sequence no_oc1_clear; !(cmd_valid && cmd_addr == 8'hdb); endsequence
  AST_RSP: assert property (clk_en && cmd_valid |=> rsp_valid) else $error("no answer");
  AST_RSP_ONE: assert property (clk_en && !cmd_valid |=> !rsp_valid) else $error("stray answer");
  AST_HS_OFF: assert property (clk_en |=> !(high_side_switch & $past(high_side_overcurrent_event)))
    else $error("tripped high side on");
  AST_LS_OFF: assert property (clk_en |=> !(low_side_switch & $past(low_side_overcurrent_event)))
    else $error("tripped low side on");
  AST_OC3_RSVD: assert property (clk_en && cmd_valid && cmd_addr[6:1] == 6'h3d |=> rsp_data[7:4] == 4'h0)
    else $error("reserved bits set");
  AST_LE_SET: assert property (oc_hit ##1 (clk_en && !cmd_valid) |=> global_load_error)
    else $error("load error missing");
  AST_LE_KEEP: assert property ($fell(global_load_error) |-> $past(cmd_valid && cmd_addr[7], 2))
    else $error("load error dropped");
  AST_HS_HOLD: assert property (clk_en && high_side_overcurrent_event[0] ##1 no_oc1_clear [*3]
    |=> !high_side_switch[0]) else $error("switch back early");
endmodule
bind ocs_status_bank ocs_status_bank_sva chk (.*);

// >>> testbench/ocs_mcu_model.sv
// Controller model issuing decoded address bytes
`timescale 1ns/1ns
module ocs_mcu_model (
  input wire core_clk,
  output logic cmd_valid = 1'h0,
  output logic [7:0] cmd_addr = 8'h00
);
  // Bit 7 low reads, bit 7 high clears
  task automatic issue(input logic [7:0] a);
    @(negedge core_clk);
    cmd_valid = 1'h1;
    cmd_addr = a;
  endtask
  // Idle address toggles so a stale byte is never mistaken for a command
  task automatic idle;
    @(negedge core_clk);
    cmd_valid = 1'h0;
    cmd_addr = ~cmd_addr;
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the status bank
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'h0, resetn = 1'h0, clk_en = 1'h1, cmd_valid, rsp_valid, global_load_error;
  logic [9:0] high_side_overcurrent_event = 10'h0, low_side_overcurrent_event = 10'h0;
  logic [9:0] high_side_switch_request = 10'h3ff, low_side_switch_request = 10'h3ff, high_side_switch, low_side_switch;
  logic [3:0] high_side_open_load_event = 4'h0, low_side_open_load_event = 4'h0;
  logic [7:0] cmd_addr, rsp_data;
  logic [31:0] e;
  localparam logic [31:0] rd_addrs = 32'h077b3b5b;
  int failures = 0, samples_checked = 0;
  // Row: high events, low events, open-load events, expected bytes
  logic [59:0] rows [4] = '{60'h0, 60'hfffffffff0fffff, 60'h005000000010002, 60'ha00188181088140};
  always #20 core_clk = ~core_clk;
  ocs_mcu_model u_mcu (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr));
  ocs_status_bank uut (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
    .high_side_overcurrent_event(high_side_overcurrent_event),
    .low_side_overcurrent_event(low_side_overcurrent_event),
    .high_side_open_load_event(high_side_open_load_event),
    .low_side_open_load_event(low_side_open_load_event),
    .high_side_switch_request(high_side_switch_request),
    .low_side_switch_request(low_side_switch_request),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch), .global_load_error(global_load_error)
  );
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] a, input logic [7:0] x);
    u_mcu.issue(a);
    u_mcu.idle();
    check("rsp_valid", {9'h0, rsp_valid}, 10'h1);
    check("rsp_data", {2'h0, rsp_data}, {2'h0, x});
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    resetn = 1'h1;
    foreach (rows[i]) begin
      @(negedge core_clk);
      {high_side_overcurrent_event, low_side_overcurrent_event, high_side_open_load_event,
        low_side_open_load_event, e} = rows[i];
      @(negedge core_clk);
      {high_side_overcurrent_event, low_side_overcurrent_event, high_side_open_load_event} = 24'h0;
      low_side_open_load_event = 4'h0;
      check("hs_sw", high_side_switch, ~rows[i][59:50]);
      check("ls_sw", low_side_switch, ~rows[i][49:40]);
      @(negedge core_clk);
      check("le", {9'h0, global_load_error}, {9'h0, |e});
      for (int r = 0; r < 32; r += 8) begin
        cmd(rd_addrs[r+:8], e[r+:8]);
        cmd(rd_addrs[r+:8] | 8'h80, e[r+:8]);
      end
      @(negedge core_clk);
      check("le", {9'h0, global_load_error}, 10'h0);
      check("hs_sw", high_side_switch, 10'h3ff);
      check("ls_sw", low_side_switch, 10'h3ff);
      $display("row %0d done", i);
    end
    high_side_overcurrent_event = 10'h001;
    @(negedge core_clk);
    high_side_overcurrent_event = 10'h0;
    cmd(8'h1b, 8'h40);
    cmd(8'h83, 8'h00);
    u_mcu.issue(8'hdb);
    u_mcu.issue(8'h5b);
    check("rsp_data", {2'h0, rsp_data}, 10'h02);
    u_mcu.idle();
    check("rsp_data", {2'h0, rsp_data}, 10'h0);
    @(negedge core_clk);
    clk_en = 1'h0;
    low_side_overcurrent_event = 10'h002;
    u_mcu.issue(8'h5b);
    u_mcu.idle();
    check("rsp_valid", {9'h0, rsp_valid}, 10'h0);
    check("ls_sw", low_side_switch, 10'h3ff);
    clk_en = 1'h1;
    low_side_overcurrent_event = 10'h0;
    cmd(8'h5b, 8'h00);
    $display("clock enable case done");
    high_side_overcurrent_event = 10'h001;
    @(negedge core_clk);
    high_side_overcurrent_event = 10'h0;
    resetn = 1'h0;
    @(negedge core_clk);
    resetn = 1'h1;
    cmd(8'hdb, 8'h00);
    $display("edge cases done");
    end_of_test;
  end
endmodule
